/* core/probe_pkg.sv */
/*
 * probe_pkg: register map, field layout, selector codes and test-bus
 * group codes of the self-test and signal-probe block.
 * assumes: one core clock, register port decoded by the top module.
 */
package probe_pkg;
	// register indices on the plain register port
	localparam logic [3:0] addr_aux_probe_select = 4'h0;
	localparam logic [3:0] addr_probe_bus_group = 4'h1;
	localparam logic [3:0] addr_selftest_arm = 4'h2;
	localparam logic [3:0] addr_dac_one = 4'h3;
	localparam logic [3:0] addr_dac_two = 4'h4;
	localparam logic [3:0] addr_command = 4'h5;
	localparam logic [3:0] addr_fifo_data = 4'h6;
	localparam logic [3:0] addr_fifo_level = 4'h7;
	localparam logic [3:0] addr_status = 4'h8;
	localparam logic [3:0] addr_bus_bit_sel = 4'h9;

	localparam logic [7:0] rst_aux_probe_select = 8'h00;
	localparam logic [4:0] rst_probe_bus_group = 5'h00;
	localparam logic [7:0] rst_selftest_arm = 8'h00;
	localparam logic [5:0] rst_dac = 6'h00;

	localparam logic [7:0] selftest_arm_code = 8'h09;
	localparam logic [3:0] cmd_idle = 4'h0;
	localparam logic [3:0] cmd_settings_store = 4'h1;
	localparam logic [3:0] cmd_checksum_calc = 4'h3;
	localparam logic [3:0] cmd_soft_reset = 4'hf;

	localparam logic [4:0] group_receiver = 5'h07;
	localparam logic [4:0] group_oscillator = 5'h0d;

	// field positions of aux_probe_select
	localparam int sel_one_lsb = 4;
	localparam int sel_two_lsb = 0;

	localparam int signature_len = 64;
	localparam int clear_len = 25;
	localparam logic [7:0] fifo_depth = 8'h40;

	typedef enum logic [3:0] {
		src_tristate = 4'b0000,
		src_dac_reg = 4'b0001,
		src_correlation = 4'b0010,
		src_res3 = 4'b0011,
		src_minimum_level = 4'b0100,
		src_adc_i = 4'b0101,
		src_adc_q = 4'b0110,
		src_res7 = 4'b0111,
		src_res8 = 4'b1000,
		src_res9 = 4'b1001,
		src_high = 4'b1010,
		src_low = 4'b1011,
		src_tx_active = 4'b1100,
		src_rx_active = 4'b1101,
		src_subcarrier = 4'b1110,
		src_bus_bit = 4'b1111
	} probe_src_t;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_run = 2'b01,
		st_done = 2'b10
	} selftest_state_t;
endpackage

/* core/probe_sel_if.sv */
/*
 * probe_sel_if: carries one auxiliary pin's selector and DAC value to the
 * pin mux, and the mux's drive decision back.
 * assumes: both ends on the same core clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface probe_sel_if;
	probe_pkg::probe_src_t source;
	logic [5:0] dac_value;
	logic [5:0] dac_level;
	logic dig_level;
	logic drive_en;
	logic analog_en;
	modport ctrl (output source, output dac_value, input dac_level, input dig_level,
		input drive_en, input analog_en);
	modport mux (input source, input dac_value, output dac_level, output dig_level,
		output drive_en, output analog_en);
endinterface
`default_nettype wire

/* core/probe_pin_mux.sv */
/*
 * probe_pin_mux: decodes one 4-bit auxiliary source selector into a DAC
 * code or a digital level with output enable.
 * assumes: internal probe signals already synchronous to mclk.
 */
`timescale 1ns/1ns
`default_nettype none
module probe_pin_mux (
	input wire logic mclk,
	input wire logic rstn,
	probe_sel_if.mux sel,
	input wire logic [5:0] correlation_signal,
	input wire logic [5:0] minimum_level_signal,
	input wire logic [5:0] adc_i_sample,
	input wire logic [5:0] adc_q_sample,
	input wire logic transmitter_active,
	input wire logic receiver_active,
	input wire logic subcarrier_detected,
	input wire logic single_probe_bus_bit
);
	logic [5:0] dac_d;
	logic dig_d;
	logic drv_d;
	logic ana_d;

	// source decode; reserved codes park the pin undriven and the dac at zero
	always_comb begin
		dac_d = 6'h00;
		dig_d = 1'b0;
		drv_d = 1'b0;
		ana_d = 1'b0;
		unique case (sel.source)
			probe_pkg::src_tristate: drv_d = 1'b0;
			probe_pkg::src_dac_reg: begin
				dac_d = sel.dac_value;
				ana_d = 1'b1;
			end
			probe_pkg::src_correlation: begin
				dac_d = correlation_signal;
				ana_d = 1'b1;
			end
			probe_pkg::src_minimum_level: begin
				dac_d = minimum_level_signal;
				ana_d = 1'b1;
			end
			probe_pkg::src_adc_i: begin
				dac_d = adc_i_sample;
				ana_d = 1'b1;
			end
			probe_pkg::src_adc_q: begin
				dac_d = adc_q_sample;
				ana_d = 1'b1;
			end
			probe_pkg::src_high: begin
				dig_d = 1'b1;
				drv_d = 1'b1;
			end
			probe_pkg::src_low: drv_d = 1'b1;
			probe_pkg::src_tx_active: begin
				dig_d = transmitter_active;
				drv_d = 1'b1;
			end
			probe_pkg::src_rx_active: begin
				dig_d = receiver_active;
				drv_d = 1'b1;
			end
			probe_pkg::src_subcarrier: begin
				dig_d = subcarrier_detected;
				drv_d = 1'b1;
			end
			probe_pkg::src_bus_bit: begin
				dig_d = single_probe_bus_bit;
				drv_d = 1'b1;
			end
			default: drv_d = 1'b0; // reserved codes stay inactive
		endcase
	end

	// registered so the pin never glitches through decode
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sel.dac_level <= 6'h00;
			sel.dig_level <= 1'b0;
			sel.drive_en <= 1'b0;
			sel.analog_en <= 1'b0;
		end else begin
			sel.dac_level <= dac_d;
			sel.dig_level <= dig_d;
			sel.drive_en <= drv_d;
			sel.analog_en <= ana_d;
		end
	end
endmodule
`default_nettype wire

/* core/test_signal_router_selftest.sv */
/*
 * test_signal_router_selftest: self-test signature generator, test bus
 * router onto six pins and two auxiliary probe pin selectors.
 * assumes: register port from the host interface on mclk; probe sources
 * on mclk except the oscillator clock, which is sampled through three flops.
 */
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module test_signal_router_selftest #(
	parameter int fifo_depth = 64,
	parameter logic [7:0] silicon_version = 8'h5a // arbitrary identity value
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic received_data,
	input wire logic bit_collision,
	input wire logic data_valid_strobe,
	input wire logic receiver_stop,
	input wire logic receiver_reset_flag,
	input wire logic oscillator_stable,
	input wire logic oscillator_raw_clock,
	input wire logic [5:0] correlation_signal,
	input wire logic [5:0] minimum_level_signal,
	input wire logic [5:0] adc_i_sample,
	input wire logic [5:0] adc_q_sample,
	input wire logic transmitter_active,
	input wire logic receiver_active,
	input wire logic subcarrier_detected,
	output logic [5:0] test_pins,
	output logic [5:0] dac_one_output,
	output logic [5:0] dac_two_output,
	output logic probe_pin_one,
	output logic probe_pin_one_oe,
	output logic probe_pin_one_analog,
	output logic probe_pin_two,
	output logic probe_pin_two_oe,
	output logic probe_pin_two_analog
);
	logic [7:0] aux_probe_select_q;
	logic [4:0] probe_bus_group_q;
	logic [7:0] selftest_arm_q;
	logic [5:0] dac_one_q;
	logic [5:0] dac_two_q;
	logic [2:0] bus_bit_sel_q;
	logic [7:0] fifo_mem [0:63];
	logic [6:0] wr_ptr_q;
	logic [6:0] rd_ptr_q;
	logic [6:0] level_q;
	logic [7:0] rdata_q;
	logic [5:0] test_pins_q;
	logic [2:0] osc_sync_q;
	logic [2:0] div_q;
	logic osc_clk_q;
	probe_pkg::selftest_state_t state_q;
	logic [6:0] sig_cnt_q;
	logic [7:0] lfsr_q;
	logic clear_count_ok_q;

	// command decode shared by soft reset, clearing pass and launch;
	// the command code sits in the low nibble of the written byte
	function automatic logic is_cmd(input logic wr, input logic [3:0] code,
		input logic [3:0] want);
		is_cmd = wr && code == want;
	endfunction

	// register decode
	// every strobe is one cycle long, so each decode fires once per access
	wire wr_sel = reg_wr && reg_addr == probe_pkg::addr_aux_probe_select;
	wire wr_grp = reg_wr && reg_addr == probe_pkg::addr_probe_bus_group;
	wire wr_arm = reg_wr && reg_addr == probe_pkg::addr_selftest_arm;
	wire wr_d1 = reg_wr && reg_addr == probe_pkg::addr_dac_one;
	wire wr_d2 = reg_wr && reg_addr == probe_pkg::addr_dac_two;
	wire wr_cmd = reg_wr && reg_addr == probe_pkg::addr_command;
	wire wr_fifo = reg_wr && reg_addr == probe_pkg::addr_fifo_data;
	wire wr_bbs = reg_wr && reg_addr == probe_pkg::addr_bus_bit_sel;
	wire rd_fifo = reg_rd && reg_addr == probe_pkg::addr_fifo_data;
	wire [3:0] cmd = reg_wdata[3:0];
	wire soft_reset = is_cmd(wr_cmd, cmd, probe_pkg::cmd_soft_reset);
	wire store_cmd = is_cmd(wr_cmd, cmd, probe_pkg::cmd_settings_store);
	wire armed = selftest_arm_q == probe_pkg::selftest_arm_code;
	wire fifo_full = level_q == 7'(fifo_depth);
	wire fifo_empty = level_q == 7'h00;
	wire running = state_q == probe_pkg::st_run;
	// checksum command while armed launches the self
	wire start_test = is_cmd(wr_cmd, cmd, probe_pkg::cmd_checksum_calc) && armed
		&& state_q != probe_pkg::st_run;
	// while running the generator owns the write side and pops are held off
	wire host_push = wr_fifo && !fifo_full && !running;
	wire sig_push = running;
	wire do_push = host_push || sig_push;
	wire do_pop = rd_fifo && !fifo_empty && !running;
	wire flush = soft_reset || start_test;
	wire last_sig = sig_cnt_q == 7'(probe_pkg::signature_len - 1);

	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	// soft reset returns the control registers to their reset values
	// the bus-bit selector goes back too, so no stale routing survives
	// a soft reset and a write never meet: both arrive over the one port
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			aux_probe_select_q <= probe_pkg::rst_aux_probe_select;
			probe_bus_group_q <= probe_pkg::rst_probe_bus_group;
			selftest_arm_q <= probe_pkg::rst_selftest_arm;
			dac_one_q <= probe_pkg::rst_dac;
			dac_two_q <= probe_pkg::rst_dac;
			bus_bit_sel_q <= 3'h0;
		end else if (soft_reset) begin
			aux_probe_select_q <= probe_pkg::rst_aux_probe_select;
			probe_bus_group_q <= probe_pkg::rst_probe_bus_group;
			selftest_arm_q <= probe_pkg::rst_selftest_arm;
			dac_one_q <= probe_pkg::rst_dac;
			dac_two_q <= probe_pkg::rst_dac;
			bus_bit_sel_q <= 3'h0;
		end else begin
			if (wr_sel)
				aux_probe_select_q <= reg_wdata;
			if (wr_grp)
				probe_bus_group_q <= reg_wdata[4:0];
			if (wr_arm)
				selftest_arm_q <= reg_wdata;
			if (wr_d1)
				dac_one_q <= reg_wdata[5:0];
			if (wr_d2)
				dac_two_q <= reg_wdata[5:0];
			if (wr_bbs)
				bus_bit_sel_q <= reg_wdata[2:0];
		end
	end

	// fifo storage; the self-test owns the write side while running
	// no reset on the array: pointers and level decide what is visible
	// host pushes are refused while running so bytes never interleave
	always_ff @(posedge mclk) begin
		if (do_push)
			fifo_mem[wr_ptr_q[5:0]] <= sig_push ? lfsr_q : reg_wdata;
	end

	// flush on soft reset and on launch; the launch drops the zero byte
	// pushed before it, so the signature starts at index zero
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_q <= 7'h00;
			rd_ptr_q <= 7'h00;
			level_q <= 7'h00;
		end else if (flush) begin
			wr_ptr_q <= 7'h00;
			rd_ptr_q <= 7'h00;
			level_q <= 7'h00;
		end else begin
			if (do_push)
				wr_ptr_q <= wr_ptr_q + 7'h01;
			if (do_pop)
				rd_ptr_q <= rd_ptr_q + 7'h01;
			level_q <= level_q + 7'(do_push) - 7'(do_pop);
		end
	end

	// the host's clearing pass: 25 zero bytes then settings store
	// only a flag for software: the launch does not wait for it
	// the byte values are not checked, only that enough arrived
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			clear_count_ok_q <= 1'b0;
		else if (store_cmd)
			clear_count_ok_q <= level_q >= 7'(probe_pkg::clear_len);
		else if (soft_reset)
			clear_count_ok_q <= 1'b0;
	end

	// signature generator: one byte per cycle, exactly 64 bytes
	// a zero state reloads the version seed, so the shift register
	// never locks up at zero; the order is fixed once the seed is
	// limitation: a stand-in sequence, not a real silicon signature
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q <= probe_pkg::st_idle;
			sig_cnt_q <= 7'h00;
			lfsr_q <= 8'h00;
		end else begin
			unique case (state_q)
				probe_pkg::st_idle, probe_pkg::st_done: begin
					if (start_test) begin
						state_q <= probe_pkg::st_run;
						sig_cnt_q <= 7'h00;
						lfsr_q <= 8'h00; // first signature byte is zero
					end
				end
				probe_pkg::st_run: begin
					lfsr_q <= (lfsr_q == 8'h00) ? silicon_version : lfsr_next(lfsr_q);
					sig_cnt_q <= sig_cnt_q + 7'h01;
					if (last_sig)
						state_q <= probe_pkg::st_done;
				end
				default: state_q <= probe_pkg::st_idle;
			endcase
		end
	end

	// a level must last two mclk periods to be seen; a faster oscillator
	// aliases, so the divided output only tracks slow enough clocks
	wire osc_agree = osc_sync_q[1] == osc_sync_q[2];
	wire osc_rise = osc_sync_q[2] && !osc_clk_q;

	// oscillator clock from another domain: three flops, count when 2 and 3 agree
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			osc_sync_q <= 3'h0;
			osc_clk_q <= 1'b0;
			div_q <= 3'h0;
		end else begin
			osc_sync_q <= {osc_sync_q[1:0], oscillator_raw_clock};
			if (osc_agree) begin
				osc_clk_q <= osc_sync_q[2];
				if (osc_rise)
					div_q <= div_q + 3'h1; // rising edges, divide by eight
			end
		end
	end

	// test bus routing; pins of unknown groups and reserved pins held low
	logic [5:0] bus_d;
	always_comb begin
		bus_d = 6'h00;
		if (probe_bus_group_q == probe_pkg::group_receiver)
			bus_d = {received_data, bit_collision, data_valid_strobe,
				receiver_stop, receiver_reset_flag, 1'b0};
		else if (probe_bus_group_q == probe_pkg::group_oscillator)
			bus_d = {oscillator_stable, div_q[2], 2'b00, osc_clk_q, 1'b0};
	end

	// one more flop so all six pins change together
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			test_pins_q <= 6'h00;
		else
			test_pins_q <= bus_d;
	end

	// register read mux, data one cycle after the strobe
	// zero outside the answer cycle and on unused indices
	// status: bit2 clearing pass seen, bit1 done, bit0 running
	wire [7:0] status_w = {5'h00, clear_count_ok_q, state_q == probe_pkg::st_done, running};
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			rdata_q <= 8'h00;
		else if (reg_rd) begin
			unique case (reg_addr)
				probe_pkg::addr_aux_probe_select: rdata_q <= aux_probe_select_q;
				probe_pkg::addr_probe_bus_group: rdata_q <= {3'h0, probe_bus_group_q};
				probe_pkg::addr_selftest_arm: rdata_q <= selftest_arm_q;
				probe_pkg::addr_dac_one: rdata_q <= {2'h0, dac_one_q};
				probe_pkg::addr_dac_two: rdata_q <= {2'h0, dac_two_q};
				probe_pkg::addr_fifo_data: rdata_q <= fifo_empty ? 8'h00 : fifo_mem[rd_ptr_q[5:0]];
				probe_pkg::addr_fifo_level: rdata_q <= {1'b0, level_q};
				probe_pkg::addr_status: rdata_q <= status_w;
				probe_pkg::addr_bus_bit_sel: rdata_q <= {5'h00, bus_bit_sel_q};
				default: rdata_q <= 8'h00;
			endcase
		end else
			rdata_q <= 8'h00;
	end
	assign reg_rdata = rdata_q;

	// auxiliary pins: one selector nibble each
	probe_sel_if sel_one ();
	probe_sel_if sel_two ();
	// an index above five is clamped onto pin six
	wire [2:0] bus_bit_idx = bus_bit_sel_q > 3'h5 ? 3'h5 : bus_bit_sel_q;
	wire single_bit = test_pins_q[bus_bit_idx];
	assign sel_one.source = probe_pkg::probe_src_t'(aux_probe_select_q[probe_pkg::sel_one_lsb +: 4]);
	assign sel_two.source = probe_pkg::probe_src_t'(aux_probe_select_q[probe_pkg::sel_two_lsb +: 4]);
	assign sel_one.dac_value = dac_one_q;
	assign sel_two.dac_value = dac_two_q;

	// both muxes share the sources; only selector and dac value differ
	// the bus bit reaches a probe pin one cycle after test_pins
	probe_pin_mux mux_one (
		.mclk(mclk),
		.rstn(rstn),
		.sel(sel_one),
		.correlation_signal(correlation_signal),
		.minimum_level_signal(minimum_level_signal),
		.adc_i_sample(adc_i_sample),
		.adc_q_sample(adc_q_sample),
		.transmitter_active(transmitter_active),
		.receiver_active(receiver_active),
		.subcarrier_detected(subcarrier_detected),
		.single_probe_bus_bit(single_bit)
	);

	probe_pin_mux mux_two (
		.mclk(mclk),
		.rstn(rstn),
		.sel(sel_two),
		.correlation_signal(correlation_signal),
		.minimum_level_signal(minimum_level_signal),
		.adc_i_sample(adc_i_sample),
		.adc_q_sample(adc_q_sample),
		.transmitter_active(transmitter_active),
		.receiver_active(receiver_active),
		.subcarrier_detected(subcarrier_detected),
		.single_probe_bus_bit(single_bit)
	);

	// every pin output comes straight from a flop
	assign test_pins = test_pins_q;
	assign dac_one_output = sel_one.dac_level;
	assign dac_two_output = sel_two.dac_level;
	assign probe_pin_one = sel_one.dig_level;
	assign probe_pin_one_oe = sel_one.drive_en;
	assign probe_pin_one_analog = sel_one.analog_en;
	assign probe_pin_two = sel_two.dig_level;
	assign probe_pin_two_oe = sel_two.drive_en;
	assign probe_pin_two_analog = sel_two.analog_en;
endmodule
`default_nettype wire

/* dv/probe_router_chk.sv */
/*
 * probe_router_chk: port-level assertions for the self-test and probe router.
 * assumes: bound to every instance of the router, one clock, async reset.
 */
`timescale 1ns/1ns
`default_nettype none
module probe_router_chk #(
	parameter int fifo_depth = 64
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [5:0] test_pins,
	input wire logic [5:0] dac_one_output,
	input wire logic [5:0] dac_two_output,
	input wire logic probe_pin_one,
	input wire logic probe_pin_one_oe,
	input wire logic probe_pin_one_analog,
	input wire logic probe_pin_two,
	input wire logic probe_pin_two_oe,
	input wire logic probe_pin_two_analog
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// selector and group writes land on the pins two or three edges later
	sequence s_aux_wr;
		reg_wr && reg_addr == probe_pkg::addr_aux_probe_select;
	endsequence
	sequence s_grp_wr;
		reg_wr && reg_addr == probe_pkg::addr_probe_bus_group;
	endsequence
	AST_ONE_HIGH: assert property (s_aux_wr ##0 reg_wdata[7:4] == 4'ha |-> ##2
		probe_pin_one && probe_pin_one_oe && !probe_pin_one_analog) else $error("pin one not high");
	AST_TWO_LOW: assert property (s_aux_wr ##0 reg_wdata[3:0] == 4'hb |-> ##2
		!probe_pin_two && probe_pin_two_oe) else $error("pin two not low");
	AST_ONE_TRI: assert property (s_aux_wr ##0 reg_wdata[7:4] == 4'h0 |-> ##2
		!probe_pin_one_oe && !probe_pin_one_analog) else $error("pin one driven");
	AST_ONE_RES: assert property (s_aux_wr ##0 reg_wdata[7:4] inside {4'h3, [4'h7:4'h9]}
		|-> ##2 !probe_pin_one_oe && !probe_pin_one_analog && dac_one_output == 6'h00)
		else $error("reserved code drives pin one");
	AST_BOTH_DAC: assert property (s_aux_wr ##0 reg_wdata == 8'h11 |-> ##2
		probe_pin_one_analog && probe_pin_two_analog) else $error("dac not on both pins");
	AST_DAC_ONE_QUIET: assert property (!probe_pin_one_analog |-> dac_one_output == 6'h00)
		else $error("dac one active while digital");
	AST_DAC_TWO_QUIET: assert property (!probe_pin_two_analog |-> dac_two_output == 6'h00)
		else $error("dac two active while digital");
	AST_PIN1_RES: assert property (test_pins[0] == 1'b0)
		else $error("test pin one driven");
	AST_OSC_RES: assert property (s_grp_wr ##0 reg_wdata[4:0] == 5'h0d |-> ##3
		test_pins[3:2] == 2'b00) else $error("reserved oscillator pins driven");
	AST_GRP_NONE: assert property (s_grp_wr ##0 reg_wdata[4:0] == 5'h1f |-> ##3
		test_pins == 6'h00) else $error("undefined group drives pins");
endmodule
bind test_signal_router_selftest probe_router_chk #(.fifo_depth(fifo_depth)) chk_u (
	.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.test_pins(test_pins), .dac_one_output(dac_one_output), .dac_two_output(dac_two_output),
	.probe_pin_one(probe_pin_one), .probe_pin_one_oe(probe_pin_one_oe),
	.probe_pin_one_analog(probe_pin_one_analog), .probe_pin_two(probe_pin_two),
	.probe_pin_two_oe(probe_pin_two_oe), .probe_pin_two_analog(probe_pin_two_analog));
`default_nettype wire

/* dv/test_test_signal_router_selftest.sv */
/*
 * test_test_signal_router_selftest: directed register-level bench.
 * assumes: package, design and checker compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none
module test_test_signal_router_selftest;
	localparam logic [7:0] sig_first = 8'h3c; // arbitrary identity value
	logic mclk, rstn, reg_wr, reg_rd;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic rxd, coll, vld, stp, rrst, ostab, oraw, txa, rxa, sub;
	logic [5:0] corr, minl, adi, adq, tp, dac1, dac2;
	logic p1, p1oe, p1an, p2, p2oe, p2an;
	int n_errors, comparisons, i;
	test_signal_router_selftest #(.fifo_depth(64), .silicon_version(sig_first)) dut_u (
		.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .received_data(rxd),
		.bit_collision(coll), .data_valid_strobe(vld), .receiver_stop(stp),
		.receiver_reset_flag(rrst), .oscillator_stable(ostab), .oscillator_raw_clock(oraw),
		.correlation_signal(corr), .minimum_level_signal(minl), .adc_i_sample(adi),
		.adc_q_sample(adq), .transmitter_active(txa), .receiver_active(rxa),
		.subcarrier_detected(sub), .test_pins(tp), .dac_one_output(dac1),
		.dac_two_output(dac2), .probe_pin_one(p1), .probe_pin_one_oe(p1oe),
		.probe_pin_one_analog(p1an), .probe_pin_two(p2), .probe_pin_two_oe(p2oe),
		.probe_pin_two_analog(p2an));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// bus cycles: one strobe cycle each, read data taken in the following cycle
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [8:0] got, input logic [8:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: pin %h expected %h", $time, got, exp);
		end
	endtask
	// drive is left out while analog, level only counts while driven
	function automatic logic [8:0] got_pin(input logic an, oe, lv, input logic [5:0] dv);
		return {an, an ? 1'b0 : oe, (oe && !an) ? lv : 1'b0, dv};
	endfunction
	function automatic logic [8:0] exp_pin(input logic [3:0] c, input logic [5:0] dv);
		case (c)
			4'h1: return {3'b100, dv};
			4'h2: return {3'b100, corr};
			4'h4: return {3'b100, minl};
			4'h5: return {3'b100, adi};
			4'h6: return {3'b100, adq};
			4'ha: return {3'b011, 6'h00};
			4'hb: return {3'b010, 6'h00};
			4'hc: return {2'b01, txa, 6'h00};
			4'hd: return {2'b01, rxa, 6'h00};
			4'he: return {2'b01, sub, 6'h00};
			4'hf: return {2'b01, tp[0], 6'h00};
			default: return 9'h000;
		endcase
	endfunction
	task automatic complete_run;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		{rstn, reg_wr, reg_rd, reg_addr, reg_wdata, d} = '0;
		{rxd, coll, vld, stp, rrst, ostab, oraw, txa, rxa, sub} = 10'b0000000101;
		{corr, minl, adi, adq} = {6'h15, 6'h2a, 6'h0c, 6'h33};
		n_errors = 0;
		comparisons = 0;
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		settle(1);
		chk_byte({p1oe, p1an, p2oe, p2an, 4'h0}, 8'h00);
		rd(4'hf); // unmapped index, the design answers zero
		// every selector code on both pins, upper nibble counts up, lower down
		wr(probe_pkg::addr_dac_one, 8'h2d);
		wr(probe_pkg::addr_dac_two, 8'h12);
		for (i = 0; i < 16; i++) begin
			wr(probe_pkg::addr_aux_probe_select, {i[3:0], 4'hf - i[3:0]});
			settle(3);
			chk_pin(got_pin(p1an, p1oe, p1, dac1), exp_pin(i[3:0], 6'h2d));
			chk_pin(got_pin(p2an, p2oe, p2, dac2), exp_pin(4'hf - i[3:0], 6'h12));
		end
		rd(probe_pkg::addr_aux_probe_select);
		chk_byte(d, 8'hf0);
		// ramp on dac one, square wave on dac two, boundary 3fh included
		wr(probe_pkg::addr_aux_probe_select, 8'h11);
		for (i = 0; i < 64; i += 9) begin
			wr(probe_pkg::addr_dac_one, i[7:0]);
			wr(probe_pkg::addr_dac_two, i[0] ? 8'h3f : 8'h00);
			settle(3);
			chk_byte({2'b00, dac1}, i[7:0]);
			chk_byte({2'b00, dac2}, i[0] ? 8'h3f : 8'h00);
		end
		rd(probe_pkg::addr_dac_one);
		chk_byte(d, 8'h3f);
		// receiver group, then inverted levels, bus bit from pin six
		@(posedge mclk);
		{rxd, coll, vld, stp, rrst} <= 5'b10101;
		wr(probe_pkg::addr_probe_bus_group, 8'h07);
		wr(probe_pkg::addr_bus_bit_sel, 8'h06);
		wr(probe_pkg::addr_aux_probe_select, 8'hff);
		settle(4);
		chk_byte({2'b00, tp}, 8'h2a);
		chk_pin(got_pin(p1an, p1oe, p1, dac1), 9'h0c0);
		@(posedge mclk);
		{rxd, coll, vld, stp, rrst} <= 5'b01010;
		settle(4);
		chk_byte({2'b00, tp}, 8'h14);
		// oscillator group: divided clock phase is free, so it is masked
		@(posedge mclk);
		{ostab, oraw} <= 2'b11;
		wr(probe_pkg::addr_probe_bus_group, 8'h0d);
		settle(6);
		chk_byte({3'b000, tp[5], tp[3:0]}, 8'h12);
		// four more oscillator rises flip the divide-by-eight pin exactly once
		d[0] = tp[4];
		repeat (4) begin
			@(posedge mclk);
			oraw <= 1'b0;
			repeat (4) @(posedge mclk);
			oraw <= 1'b1;
			repeat (3) @(posedge mclk);
		end
		settle(6);
		chk_byte({7'h00, tp[4]}, {7'h00, ~d[0]});
		wr(probe_pkg::addr_probe_bus_group, 8'h1f);
		settle(4);
		chk_byte({2'b00, tp}, 8'h00);
		// checksum without arming leaves the pushed byte alone
		wr(probe_pkg::addr_command, 8'h0f);
		rd(probe_pkg::addr_aux_probe_select);
		chk_byte(d, 8'h00);
		wr(probe_pkg::addr_fifo_data, 8'h00);
		wr(probe_pkg::addr_command, 8'h03);
		settle(80);
		rd(probe_pkg::addr_fifo_level);
		chk_byte(d, 8'h01);
		// full self-test procedure
		wr(probe_pkg::addr_command, 8'h0f);
		for (i = 0; i < 25; i++) begin
			wr(probe_pkg::addr_fifo_data, 8'h00);
		end
		wr(probe_pkg::addr_command, 8'h01);
		rd(probe_pkg::addr_status);
		chk_byte(d, 8'h04);
		wr(probe_pkg::addr_selftest_arm, 8'h09);
		wr(probe_pkg::addr_fifo_data, 8'h00);
		wr(probe_pkg::addr_command, 8'h03);
		d = 8'h00;
		for (i = 0; i < 100 && d[1] !== 1'b1; i++) begin
			rd(probe_pkg::addr_status);
		end
		if (d[1] !== 1'b1) begin
			n_errors++;
			$display("Error at %0t: self-test never finished", $time);
		end else begin
			rd(probe_pkg::addr_fifo_level);
			chk_byte(d, 8'h40);
			rd(probe_pkg::addr_fifo_data);
			chk_byte(d, 8'h00);
			rd(probe_pkg::addr_fifo_data);
			chk_byte(d, sig_first);
			rd(probe_pkg::addr_fifo_level);
			chk_byte(d, 8'h3e);
		end
		complete_run();
	end
endmodule
`default_nettype wire
